//--- logic/i2c_bus_condition_sequencer.sv
// bus condition detection and controller restart/ack/stop sequencing
// Notes on behaviour
// - start is SDA falling while SCL high
// - stop valid only after an SCL low
// - restart resets target logic like a start
// - 10-bit read needs restart with high byte
// - prior-match flag held until stop or mismatch
// - enable bits add start/stop target interrupts
// - restart: SCL low, release SDA one period
// - release SCL, both high, SDA low period
// - restart request self-clears, SDA stays low
// - start status immediate, irq after timeout
// - restart request ignored while busy
// - restart collision on SDA low or SCL low
// - ack: SCL low, drive ack bit, one period
// - after SCL high, one period, go idle
// - buffer write during ack/stop sets collision
// - stop: drive SDA low, reload generator
// - release SCL, then SDA, flag stop seen
// - one period later clear stop, set irq
`timescale 1ns/1ps
module i2c_bus_condition_sequencer
	import bus_seq_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic bus_clock_pin_in,
	output logic bus_clock_pin_out,
	output logic bus_clock_pin_oe_n,
	input wire logic bus_data_pin_in,
	output logic bus_data_pin_out,
	output logic bus_data_pin_oe_n,
	input wire logic [BAUD_W-1:0] baud_reload,
	input wire seq_req_t req_set,
	input wire logic ack_data_bit,
	input wire logic buffer_write,
	input wire logic [7:0] buffer_wdata,
	input wire logic target_mode,
	input wire logic target_native_irq,
	input wire logic start_irq_enable,
	input wire logic stop_irq_enable,
	input wire logic addr_byte_valid,
	input wire logic addr_byte_first,
	input wire logic [7:0] addr_byte,
	input wire logic [9:0] own_address,
	input wire logic flag_clear,
	output seq_req_t req_status,
	output cond_t port_status_reg,
	output logic port_irq_flag,
	output logic bus_collision,
	output logic write_collision_flag,
	output logic [7:0] transmit_buffer,
	output logic prior_match,
	output logic target_reset
);
	typedef enum logic [3:0] {
		IDLE, RS_LOW, RS_SDA_HI, RS_SCL_HI, RS_SDA_LO, AK_LOW, AK_WAIT, AK_HI,
		PS_SDA_LO, PS_SCL_HI, PS_SDA_HI, PS_DONE
	} seq_state_t;

	////////////////////////////////////////////////////////////////
	logic scl_s1_reg, scl_reg, sda_s1_reg, sda_reg, scl_d_reg, sda_d_reg;
	always_ff @(posedge core_clk or negedge rst_n)
		if (!rst_n)
		begin
			scl_s1_reg <= 1'b1;
			scl_reg <= 1'b1;
			sda_s1_reg <= 1'b1;
			sda_reg <= 1'b1;
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end
		else
		begin
			scl_s1_reg <= bus_clock_pin_in;
			scl_reg <= scl_s1_reg;
			sda_s1_reg <= bus_data_pin_in;
			sda_reg <= sda_s1_reg;
			scl_d_reg <= scl_reg;
			sda_d_reg <= sda_reg;
		end

	wire start_det = sda_d_reg && !sda_reg && scl_reg && scl_d_reg;
	wire stop_edge = !sda_d_reg && sda_reg && scl_reg && scl_d_reg;
	logic scl_low_seen_reg;
	// a start alone does not arm stop detection; SCL must go low first
	wire stop_det = stop_edge && scl_low_seen_reg;
	always_ff @(posedge core_clk or negedge rst_n)
		if (!rst_n)
			scl_low_seen_reg <= 1'b0;
		else if (start_det || stop_det)
			scl_low_seen_reg <= 1'b0;
		else if (!scl_reg)
			scl_low_seen_reg <= 1'b1;

	////////////////////////////////////////////////////////////////
	logic [BAUD_W-1:0] baud_cnt_reg;
	logic baud_run_reg;
	seq_state_t state_reg, state_next;
	logic baud_load;
	wire baud_tick = baud_run_reg && (baud_cnt_reg == BAUD_ONE);
	always_ff @(posedge core_clk or negedge rst_n)
		if (!rst_n)
		begin
			baud_cnt_reg <= BAUD_RESET;
			baud_run_reg <= 1'b0;
		end
		else if (baud_load)
		begin
			baud_cnt_reg <= baud_reload;
			baud_run_reg <= 1'b1;
		end
		else if (baud_tick || state_next == IDLE)
			baud_run_reg <= 1'b0;
		else if (baud_run_reg)
			baud_cnt_reg <= baud_cnt_reg - BAUD_ONE;

	////////////////////////////////////////////////////////////////
	seq_req_t req_reg;
	logic scl_drv_low, sda_drv_low, clr_rs, clr_ack, clr_stop, irq_set, bcol_set;
	logic stop_seen_seq_reg;
	wire idle = state_reg == IDLE;
	always_comb
	begin
		state_next = state_reg;
		baud_load = 1'b0;
		scl_drv_low = 1'b0;
		sda_drv_low = 1'b0;
		clr_rs = 1'b0;
		clr_ack = 1'b0;
		clr_stop = 1'b0;
		irq_set = 1'b0;
		bcol_set = 1'b0;
		unique case (state_reg)
			IDLE:
				if (req_reg.repeated_start_request)
					state_next = RS_LOW;
				else if (req_reg.ack_sequence_enable)
				begin
					state_next = AK_LOW;
					baud_load = 1'b1;
				end
				else if (req_reg.stop_request)
					state_next = PS_SDA_LO;
			RS_LOW:
			begin
				scl_drv_low = 1'b1;
				if (!scl_reg && !baud_run_reg)
					baud_load = 1'b1;
				if (baud_tick && sda_reg)
					state_next = RS_SDA_HI;
			end
			RS_SDA_HI:
				if (scl_reg)
				begin
					state_next = RS_SCL_HI;
					baud_load = 1'b1;
					bcol_set = !sda_reg;
				end
			RS_SCL_HI:
			begin
				if (!scl_reg)
				begin
					bcol_set = 1'b1;
					state_next = IDLE;
					clr_rs = 1'b1;
				end
				else if (!sda_reg)
				begin
					bcol_set = 1'b1;
					state_next = IDLE;
					clr_rs = 1'b1;
				end
				else if (baud_tick)
				begin
					state_next = RS_SDA_LO;
					baud_load = 1'b1;
				end
			end
			RS_SDA_LO:
			begin
				sda_drv_low = 1'b1;
				if (baud_tick)
				begin
					// hold_low takes over from here so SDA stays held low and SCL is pulled low
					clr_rs = 1'b1;
					irq_set = 1'b1;
					state_next = IDLE;
				end
			end
			AK_LOW:
			begin
				scl_drv_low = 1'b1;
				sda_drv_low = !ack_data_bit;
				if (baud_tick)
					state_next = AK_WAIT;
			end
			AK_WAIT:
			begin
				sda_drv_low = !ack_data_bit;
				if (scl_reg)
				begin
					baud_load = 1'b1;
					state_next = AK_HI;
				end
			end
			AK_HI:
			begin
				sda_drv_low = !ack_data_bit;
				if (baud_tick)
				begin
					clr_ack = 1'b1;
					irq_set = 1'b1;
					state_next = IDLE;
				end
			end
			PS_SDA_LO:
			begin
				scl_drv_low = 1'b1;
				sda_drv_low = 1'b1;
				if (!sda_reg && !baud_run_reg)
					baud_load = 1'b1;
				if (baud_tick)
				begin
					state_next = PS_SCL_HI;
					baud_load = 1'b1;
				end
			end
			PS_SCL_HI:
			begin
				sda_drv_low = 1'b1;
				if (baud_tick)
					state_next = PS_SDA_HI;
			end
			PS_SDA_HI:
				if (stop_seen_seq_reg)
				begin
					baud_load = 1'b1;
					state_next = PS_DONE;
				end
			PS_DONE:
				if (baud_tick)
				begin
					clr_stop = 1'b1;
					irq_set = 1'b1;
					state_next = IDLE;
				end
			default:
				state_next = IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n)
		if (!rst_n)
			state_reg <= IDLE;
		else
			state_reg <= state_next;

	// restart taken only when idle and nothing else pending
	wire rs_accept = req_set.repeated_start_request && idle
		&& !req_reg.ack_sequence_enable && !req_reg.stop_request;
	always_ff @(posedge core_clk or negedge rst_n)
		if (!rst_n)
			req_reg <= '0;
		else
		begin
			req_reg.repeated_start_request <= rs_accept
				|| (req_reg.repeated_start_request && !clr_rs);
			req_reg.ack_sequence_enable <= (req_set.ack_sequence_enable && idle)
				|| (req_reg.ack_sequence_enable && !clr_ack);
			req_reg.stop_request <= (req_set.stop_request && idle)
				|| (req_reg.stop_request && !clr_stop);
		end

	always_ff @(posedge core_clk or negedge rst_n)
		if (!rst_n)
			stop_seen_seq_reg <= 1'b0;
		else
			stop_seen_seq_reg <= state_reg == PS_SDA_HI && sda_reg && scl_reg;

	////////////////////////////////////////////////////////////////
	wire ack_or_stop_busy = req_reg.ack_sequence_enable || req_reg.stop_request;
	wire write_collision_flag_set = buffer_write && ack_or_stop_busy;
	wire cond_irq = target_mode && !target_native_irq
		&& ((start_det && start_irq_enable) || (stop_det && stop_irq_enable));
	always_ff @(posedge core_clk or negedge rst_n)
		if (!rst_n)
		begin
			port_status_reg <= '0;
			port_irq_flag <= 1'b0;
			bus_collision <= 1'b0;
			write_collision_flag <= 1'b0;
			transmit_buffer <= 8'h00;
			target_reset <= 1'b0;
		end
		else
		begin
			// sets win over a simultaneous clear
			port_status_reg.start_seen <= start_det || (port_status_reg.start_seen
				&& !stop_det);
			port_status_reg.stop_seen <= stop_det || (port_status_reg.stop_seen
				&& !start_det);
			port_irq_flag <= irq_set || cond_irq || (port_irq_flag && !flag_clear);
			bus_collision <= bcol_set || (bus_collision && !flag_clear);
			write_collision_flag <= write_collision_flag_set || (write_collision_flag && !flag_clear);
			if (buffer_write && !ack_or_stop_busy)
				transmit_buffer <= buffer_wdata;
			target_reset <= start_det;
		end

	////////////////////////////////////////////////////////////////
	// restart and start look alike on the wire, so both reset target state
	wire hi_byte = addr_byte[7:3] == HIGH_ADDR_MARK;
	wire hi_match = hi_byte && addr_byte[2:1] == own_address[9:8];
	logic hi_ok_reg;
	always_ff @(posedge core_clk or negedge rst_n)
		if (!rst_n)
		begin
			hi_ok_reg <= 1'b0;
			prior_match <= 1'b0;
		end
		else if (stop_det)
		begin
			hi_ok_reg <= 1'b0;
			prior_match <= 1'b0;
		end
		else if (start_det)
			hi_ok_reg <= 1'b0;
		else if (addr_byte_valid && addr_byte_first)
		begin
			hi_ok_reg <= hi_match && !addr_byte[0];
			if (!hi_match || !addr_byte[0])
				prior_match <= 1'b0;
		end
		else if (addr_byte_valid && hi_ok_reg && addr_byte == own_address[7:0])
			prior_match <= 1'b1;

	////////////////////////////////////////////////////////////////
	logic scl_oe_n_reg, sda_oe_n_reg;
	logic held_reg;
	// a finished restart keeps both lines low until the next sequence takes over
	wire hold_low = (state_reg == RS_SDA_LO && baud_tick) || (held_reg && idle);
	always_ff @(posedge core_clk or negedge rst_n)
		if (!rst_n)
		begin
			scl_oe_n_reg <= 1'b1;
			sda_oe_n_reg <= 1'b1;
			held_reg <= 1'b0;
		end
		else
		begin
			scl_oe_n_reg <= !(scl_drv_low || hold_low);
			sda_oe_n_reg <= !(sda_drv_low || hold_low);
			held_reg <= hold_low;
		end
	always_comb
	begin
		bus_clock_pin_oe_n = scl_oe_n_reg;
		bus_data_pin_oe_n = sda_oe_n_reg;
		bus_clock_pin_out = 1'b0;
		bus_data_pin_out = 1'b0;
		req_status = req_reg;
	end

	////////////////////////////////////////////////////////////////
	a_start_status: assert property (@(posedge core_clk) disable iff (!rst_n)
		start_det |=> port_status_reg.start_seen) else $error("start not flagged");
	a_stop_needs_low: assert property (@(posedge core_clk) disable iff (!rst_n)
		stop_det |-> $past(scl_low_seen_reg)) else $error("stop without low");
	a_rs_ignored: assert property (@(posedge core_clk) disable iff (!rst_n)
		(req_set.repeated_start_request && !idle && !req_reg.repeated_start_request)
		|=> !req_reg.repeated_start_request) else $error("busy restart taken");
	a_write_collision_flag_keep: assert property (@(posedge core_clk) disable iff (!rst_n)
		write_collision_flag_set |=> write_collision_flag && $stable(transmit_buffer))
		else $error("write collision missed");
	a_rs_scl_low: assert property (@(posedge core_clk) disable iff (!rst_n)
		state_reg == RS_LOW |=> !bus_clock_pin_oe_n) else $error("scl not low");
	a_rs_done: assert property (@(posedge core_clk) disable iff (!rst_n)
		(state_reg == RS_SDA_LO && baud_tick) |=> !req_reg.repeated_start_request
		&& port_irq_flag && !bus_data_pin_oe_n) else $error("restart end wrong");
	a_ack_done: assert property (@(posedge core_clk) disable iff (!rst_n)
		(state_reg == AK_HI && baud_tick) |=> !req_reg.ack_sequence_enable
		&& idle) else $error("ack end wrong");
	a_stop_done: assert property (@(posedge core_clk) disable iff (!rst_n)
		(state_reg == PS_DONE && baud_tick) |=> !req_reg.stop_request
		&& port_irq_flag) else $error("stop end wrong");
	a_baud_load: assert property (@(posedge core_clk) disable iff (!rst_n)
		baud_load |=> baud_cnt_reg == $past(baud_reload)) else $error("no reload");
	a_rs_coll: assert property (@(posedge core_clk) disable iff (!rst_n)
		(state_reg == RS_SCL_HI && !scl_reg) |=> bus_collision)
		else $error("collision missed");
endmodule : i2c_bus_condition_sequencer

//--- logic/bus_seq_pkg.sv
// shared constants and types for the bus condition sequencer
package bus_seq_pkg;
	localparam int BAUD_W = 8;
	localparam logic [BAUD_W-1:0] BAUD_RESET = 8'h00;
	localparam logic [BAUD_W-1:0] BAUD_ONE = 8'h01;
	localparam logic [6:0] ADDR_RESET = 7'h00;
	localparam logic [4:0] HIGH_ADDR_MARK = 5'h1E;
	typedef struct packed {
		logic repeated_start_request;
		logic ack_sequence_enable;
		logic stop_request;
	} seq_req_t;
	typedef struct packed {
		logic start_seen;
		logic stop_seen;
	} cond_t;
endpackage : bus_seq_pkg

//--- verif/bus_far_side.sv
// far side of the two-wire bus: other controllers and targets
`timescale 1ns/1ps
module bus_far_side
(
	input wire logic scl_oe_n,
	input wire logic sda_oe_n,
	output logic scl,
	output logic sda
);
	logic hold_scl;
	logic hold_sda;
	////////////////////////////////////////////////////////////////////////////
	// wired-and with pull-ups: a released line reads high, never the old value
	assign scl = ~(~scl_oe_n | hold_scl);
	assign sda = ~(~sda_oe_n | hold_sda);
	initial
	begin
		hold_scl = 1'b0;
		hold_sda = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////////
	// one half of an 800 ns link clock per step; data moves only under the
	// ordering the caller picks, so starts and stops come out as framed
	task automatic step(input logic c, input logic d);
		hold_scl = c;
		hold_sda = d;
		#400;
	endtask : step
endmodule : bus_far_side

//--- verif/i2c_bus_condition_sequencer_test.sv
// self-checking bench for the bus condition sequencer
`timescale 1ns/1ps
module i2c_bus_condition_sequencer_test
	import bus_seq_pkg::*;
;
	localparam seq_req_t RS = 3'b100;
	localparam seq_req_t AK = 3'b010;
	localparam seq_req_t SP = 3'b001;
	logic core_clk = 1'b0;
	logic rst_n;
	logic scl, sda, scl_oe_n, sda_oe_n, ack_data_bit, buffer_write, flag_clear;
	logic target_mode, start_irq_enable, addr_byte_valid, addr_byte_first;
	logic [7:0] buffer_wdata, addr_byte, transmit_buffer;
	seq_req_t req_set, req_status;
	cond_t stat;
	logic port_irq_flag, bus_collision, write_collision_flag, prior_match, target_reset;
	int errors = 0, comparisons = 0, cycles = 0, resets = 0;
	always #50 core_clk = ~core_clk;
	bus_far_side p (.scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n), .scl(scl), .sda(sda));
	i2c_bus_condition_sequencer dut (
		.core_clk(core_clk), .rst_n(rst_n), .bus_clock_pin_in(scl), .bus_clock_pin_out(),
		.bus_clock_pin_oe_n(scl_oe_n), .bus_data_pin_in(sda), .bus_data_pin_out(),
		.bus_data_pin_oe_n(sda_oe_n), .baud_reload(8'h08), .req_set(req_set),
		.ack_data_bit(ack_data_bit), .buffer_write(buffer_write), .buffer_wdata(buffer_wdata),
		.target_mode(target_mode), .target_native_irq(1'b0),
		.start_irq_enable(start_irq_enable), .stop_irq_enable(start_irq_enable),
		.addr_byte_valid(addr_byte_valid), .addr_byte_first(addr_byte_first),
		.addr_byte(addr_byte), .own_address(10'h2B5), .flag_clear(flag_clear),
		.req_status(req_status), .port_status_reg(stat), .port_irq_flag(port_irq_flag),
		.bus_collision(bus_collision), .write_collision_flag(write_collision_flag),
		.transmit_buffer(transmit_buffer), .prior_match(prior_match),
		.target_reset(target_reset));
	////////////////////////////////////////////////////////////////////////////
	function automatic logic probe(input int sel);
		case (sel)
			0: return stat.start_seen === 1'b1;
			1: return stat.stop_seen === 1'b1;
			2: return req_status === 3'b000;
			3: return scl_oe_n === 1'b1;
			4: return scl_oe_n === 1'b0;
			default: return bus_collision === 1'b1;
		endcase
	endfunction : probe
	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp)
		begin
			errors++;
			$display("unexpected %s: expected %h seen %h", name, exp, got);
		end
	endtask : check
	// bounded so a stuck sequence shows as one mismatch, not a hang
	task automatic wait_for(input string name, input int sel);
		int n;
		n = 0;
		while (!probe(sel) && n < 200)
		begin
			@(negedge core_clk);
			n++;
		end
		check(name, 8'h01, {7'h00, probe(sel)});
	endtask : wait_for
	task automatic request(input seq_req_t r);
		@(negedge core_clk);
		req_set = r;
		@(negedge core_clk);
		req_set = 3'b000;
	endtask : request
	task automatic write_buf(input logic [7:0] d);
		@(negedge core_clk);
		buffer_write = 1'b1;
		buffer_wdata = d;
		@(negedge core_clk);
		buffer_write = 1'b0;
	endtask : write_buf
	task automatic send_addr(input logic first, input logic [7:0] d);
		@(negedge core_clk);
		addr_byte_valid = 1'b1;
		addr_byte_first = first;
		addr_byte = d;
		@(negedge core_clk);
		addr_byte_valid = 1'b0;
		@(negedge core_clk);
	endtask : send_addr
	task automatic clear_flags();
		@(negedge core_clk);
		flag_clear = 1'b1;
		@(negedge core_clk);
		flag_clear = 1'b0;
	endtask : clear_flags
	task automatic finish_test();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : finish_test
	////////////////////////////////////////////////////////////////////////////
	always @(posedge core_clk)
	begin
		cycles++;
		if (target_reset === 1'b1)
			resets++;
		if (cycles == 20000)
		begin
			errors++;
			finish_test();
		end
	end
	initial
	begin
		int r0;
		int e;
		rst_n = 1'b0;
		req_set = 3'b000;
		{ack_data_bit, buffer_write, flag_clear, target_mode, start_irq_enable} = 5'h00;
		{addr_byte_valid, addr_byte_first, buffer_wdata, addr_byte} = 18'h00000;
		repeat (10) @(negedge core_clk);
		rst_n = 1'b1;
		repeat (2) @(negedge core_clk);
		check("pin enables", 8'h03, {6'h00, scl_oe_n, sda_oe_n});
		check("requests", 8'h00, {5'h00, req_status});
		write_buf(8'hA5);
		check("buffer", 8'hA5, transmit_buffer);
		// another controller: start, a data glitch under high clock, then a real stop
		target_mode = 1'b1;
		for (e = 0; e < 2; e++)
		begin
			start_irq_enable = e[0];
			r0 = resets;
			p.step(1'b0, 1'b1);
			wait_for("start seen", 0);
			repeat (2) @(negedge core_clk);
			check("start irq", {7'h00, e[0]}, {7'h00, port_irq_flag});
			check("target reset", 8'h01, 8'(resets - r0));
			clear_flags();
			p.step(1'b0, 1'b0);
			repeat (6) @(negedge core_clk);
			check("stop seen", 8'h00, {7'h00, stat.stop_seen});
			p.step(1'b1, 1'b0);
			p.step(1'b1, 1'b1);
			p.step(1'b0, 1'b1);
			p.step(1'b0, 1'b0);
			wait_for("stop seen", 1);
			check("stop irq", {7'h00, e[0]}, {7'h00, port_irq_flag});
			clear_flags();
		end
		target_mode = 1'b0;
		send_addr(1'b1, 8'hF4);
		send_addr(1'b0, 8'hB5);
		check("prior match", 8'h01, {7'h00, prior_match});
		send_addr(1'b1, 8'hF2);
		check("prior match", 8'h00, {7'h00, prior_match});
		send_addr(1'b1, 8'hF4);
		send_addr(1'b0, 8'hB5);
		// restart from idle; a stop asked for meanwhile is dropped
		r0 = resets;
		request(RS);
		request(SP);
		check("stop refused", 8'h00, {7'h00, req_status.stop_request});
		wait_for("restart start", 0);
		check("irq early", 8'h00, {7'h00, port_irq_flag});
		wait_for("restart done", 2);
		check("irq late", 8'h01, {7'h00, port_irq_flag});
		check("sda held", 8'h00, {7'h00, sda_oe_n});
		check("target reset", 8'h01, 8'(resets - r0));
		repeat (10) @(negedge core_clk);
		check("lines held", 8'h00, {6'h00, scl_oe_n, sda_oe_n});
		check("no collision", 8'h00, {7'h00, bus_collision});
		clear_flags();
		// stop, with a buffer write and a restart request thrown in
		request(SP);
		write_buf(8'h3C);
		check("write collision", 8'h01, {7'h00, write_collision_flag});
		check("buffer", 8'hA5, transmit_buffer);
		request(RS);
		check("restart refused", 8'h00, {7'h00, req_status.repeated_start_request});
		wait_for("stop seen", 1);
		check("stop pending", 8'h01, {7'h00, req_status.stop_request});
		check("irq early", 8'h00, {7'h00, port_irq_flag});
		wait_for("stop done", 2);
		check("irq late", 8'h01, {7'h00, port_irq_flag});
		check("pin enables", 8'h03, {6'h00, scl_oe_n, sda_oe_n});
		check("prior match", 8'h00, {7'h00, prior_match});
		clear_flags();
		// ack then nack; the far side stretches the clock each time
		for (e = 0; e < 2; e++)
		begin
			ack_data_bit = e[0];
			request(AK);
			repeat (3) @(negedge core_clk);
			check("ack clock", 8'h00, {7'h00, scl_oe_n});
			check("ack data", {7'h00, e[0]}, {7'h00, sda_oe_n});
			write_buf(8'h5A);
			check("write collision", 8'h01, {7'h00, write_collision_flag});
			p.step(1'b1, 1'b0);
			repeat (10) @(negedge core_clk);
			check("ack stretched", 8'h01, {7'h00, req_status.ack_sequence_enable});
			p.step(1'b0, 1'b0);
			wait_for("ack done", 2);
			check("buffer", 8'hA5, transmit_buffer);
			clear_flags();
		end
		// restart while another controller drags data low in the high phase
		request(RS);
		wait_for("clock driven", 4);
		wait_for("clock released", 3);
		p.step(1'b0, 1'b1);
		wait_for("collision", 5);
		p.step(1'b0, 1'b0);
		finish_test();
	end
endmodule : i2c_bus_condition_sequencer_test
